// *** shared/scsi_arb_defines.vh ***
/*
 * Constants for the parallel bus arbiter: register offsets, field
 * positions, reset values and timing figures.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SCSI_ARB_DEFINES_VH
`define SCSI_ARB_DEFINES_VH

// System clock rate in MHz (4 ns period)
`define SYS_CLK_MHZ 8'hfa

// Device count equals data path bits: 2 bytes -> 16 IDs
`define BUS_WIDTH_BYTES 2
`define NUM_IDS 16
`define ID_W 4

// Register byte offsets
`define OFF_ARB_DELAY 8'h00
`define OFF_BUS_FREE 8'h04
`define OFF_REQ_DELAY 8'h08
`define OFF_TIMEOUT 8'h0c
`define OFF_FREQ 8'h10
`define OFF_STATUS 8'h14
`define OFF_MASK 8'h18
`define OFF_STATE 8'h1c
`define OFF_PENDING 8'h20

// Reset values, in bus cycles except the rate in MHz
`define RST_ARB_DELAY 16'h0018
`define RST_BUS_FREE 16'h0008
`define RST_REQ_DELAY 16'h000d
`define RST_TIMEOUT 24'h002710
`define RST_FREQ 8'h0a

// Recommended real selection timeout, for reference
`define TIMEOUT_RECOMMENDED_MS 250

// Status and mask bit positions
`define EV_GRANT 0
`define EV_DELIVER 1
`define EV_TIMEOUT 2
`define EV_DONE 3
`define EV_W 4

// State register field positions
`define ST_STATE_LSB 0
`define ST_OWNER_LSB 4
`define ST_OWNED_BIT 8

`endif

// *** hw/bus_tick_gen.v ***
/*
 * Bus cycle tick generator: converts a bus rate in MHz into one
 * clock-wide tick per bus cycle by fractional accumulation.
 * Assumes freq_mhz no larger than the system clock rate in MHz.
 */
`timescale 1ns/10ps
`include "scsi_arb_defines.vh"

module bus_tick_gen (
    // Clock and control
    input wire clk,
    input wire sys_rst,
    input wire ce,
    // Rate in MHz
    input wire [7:0] freq_mhz,
    // One pulse per bus cycle
    output reg tick
);

reg [8:0] acc_reg;
wire [8:0] acc_sum;

assign acc_sum = acc_reg + {1'b0, freq_mhz};

////////////////////////////////////////////////////////////////////////
// Accumulate the rate, tick on each wrap of the clock rate
always @(posedge clk) begin
    if (sys_rst) begin
        acc_reg <= 9'h000;
        tick <= 1'b0;
    end else if (ce) begin
        if (acc_sum >= {1'b0, `SYS_CLK_MHZ}) begin
            acc_reg <= acc_sum - {1'b0, `SYS_CLK_MHZ};
            tick <= 1'b1;
        end else begin
            acc_reg <= acc_sum;
            tick <= 1'b0;
        end
    end
end

endmodule // bus_tick_gen

// *** hw/prio_pick.v ***
/*
 * Priority picker: registered ID of the highest set request bit.
 * Assumes the request vector is synchronous to clk.
 */
`timescale 1ns/10ps
`include "scsi_arb_defines.vh"

module prio_pick (
    // Clock and control
    input wire clk,
    input wire sys_rst,
    input wire ce,
    // Request vector
    input wire [`NUM_IDS-1:0] req,
    // Registered winner
    output reg [`ID_W-1:0] win_id,
    output reg win_valid
);

integer i;
reg [`ID_W-1:0] id_next;

////////////////////////////////////////////////////////////////////////
// Highest index wins since later loop passes overwrite
always @* begin
    id_next = {`ID_W{1'b0}};
    for (i = 0; i < `NUM_IDS; i = i + 1) begin
        if (req[i]) begin
            id_next = i[`ID_W-1:0];
        end
    end
end

always @(posedge clk) begin
    if (sys_rst) begin
        win_id <= {`ID_W{1'b0}};
        win_valid <= 1'b0;
    end else if (ce) begin
        win_id <= id_next;
        win_valid <= |req;
    end
end

endmodule // prio_pick

// *** hw/scsi_bus_arbiter.v ***
/*
 * Arbiter and phase timer for a shared 16-ID parallel bus, with an
 * AHB-Lite register slave and one level interrupt.
 * Assumes all inputs synchronous to clk; devices hold sel_target
 * valid while granted and pulse xfer_done when the transaction ends.
 */
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`include "scsi_arb_defines.vh"

// Summary of operation
// RULE1: Devices may request anytime; requests are latched until granted.
// RULE2: After a transaction, wait bus-free plus arbitration delay first.
// RULE3: On idle bus, evaluate arbitration delay after first request.
// RULE4: Highest requesting ID wins the bus.
// RULE5: Sixteen IDs, one per bit of a two-byte data path.
// RULE6: Deliver request to target after request delay, default 13.
// RULE7: Target decides response delay, including data transfer time.
// RULE8: Arbitration delay configurable in bus cycles, default 24.
// RULE9: Bus-free gap configurable in bus cycles, default 8.
// RULE10: Selection timeout default 10000 cycles; 250 ms recommended.
// RULE11: Delays in bus cycles; rate in MHz, default 10, vs clock.
// RULE12: Missing target yields timeout response after timeout cycles.
// RULE13: Target answers connect, disconnect, save pointer, busy, reject. Not decoded here: the target only pulses xfer_done.
// RULE14: At most one grant, held until its transaction completes.
module scsi_bus_arbiter (
    // Clock, reset, enable
    input wire clk,
    input wire sys_rst,
    input wire ce,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Device side
    input wire [`NUM_IDS-1:0] arb_req, // RULE5
    input wire [`ID_W-1:0] sel_target,
    input wire [`NUM_IDS-1:0] target_present,
    input wire xfer_done,
    output reg [`NUM_IDS-1:0] grant,
    output reg deliver,
    output reg [`ID_W-1:0] deliver_target,
    output reg timeout_resp,
    // Interrupt
    output reg irq
);

// Arbiter states
localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_ARB = 3'h1;
localparam [2:0] S_REQ = 3'h2;
localparam [2:0] S_BUSY = 3'h3;
localparam [2:0] S_TMO = 3'h4;

// Configuration registers
reg [15:0] arb_delay_reg;
reg [15:0] bus_free_reg;
reg [15:0] req_delay_reg;
reg [23:0] timeout_reg;
reg [7:0] freq_reg;
reg [`EV_W-1:0] status_reg;
reg [`EV_W-1:0] mask_reg;

// Arbiter state
reg [2:0] state_reg;
reg [2:0] state_next;
reg [23:0] cnt_reg;
reg [23:0] cnt_next;
reg [`NUM_IDS-1:0] pend_reg;
reg [`NUM_IDS-1:0] pend_clr;
reg [`ID_W-1:0] owner_reg;
reg [`ID_W-1:0] owner_next;
reg owned_reg;
reg owned_next;
reg [`EV_W-1:0] ev;

// Bus slave data phase
reg wr_pend_reg;
reg [7:0] wr_addr_reg;
reg [31:0] rd_data;

wire tick;
wire [`ID_W-1:0] win_id;
wire win_valid;
wire addr_phase;
wire expired;
wire [23:0] gap_cycles;

assign addr_phase = hsel & hready & htrans[1];
assign expired = (cnt_reg == 24'h000000);
assign gap_cycles = {8'h00, bus_free_reg} + {8'h00, arb_delay_reg}; // RULE2

// One-hot grant vector for an owner ID
function [`NUM_IDS-1:0] onehot;
    input [`ID_W-1:0] id;
    begin
        onehot = {{(`NUM_IDS-1){1'b0}}, 1'b1} << id;
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Bus cycle tick from configured rate
bus_tick_gen u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .freq_mhz(freq_reg), // RULE11
    .tick(tick)
);

// Highest pending ID
prio_pick u_pick (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .req(pend_reg), // RULE4
    .win_id(win_id),
    .win_valid(win_valid)
);

////////////////////////////////////////////////////////////////////////
// Arbitration and phase sequencing
always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    owner_next = owner_reg;
    owned_next = owned_reg;
    pend_clr = {`NUM_IDS{1'b0}};
    ev = {`EV_W{1'b0}};
    if (state_reg != S_IDLE && tick && !expired) begin
        cnt_next = cnt_reg - 24'h000001;
    end
    case (state_reg)
        S_IDLE: begin
            if (|pend_reg) begin
                state_next = S_ARB; // RULE3
                cnt_next = {8'h00, arb_delay_reg}; // RULE8
            end
        end
        S_ARB: begin
            if (expired) begin
                if (win_valid) begin
                    state_next = S_REQ;
                    owner_next = win_id; // RULE4
                    owned_next = 1'b1; // RULE14
                    pend_clr = onehot(win_id);
                    cnt_next = {8'h00, req_delay_reg}; // RULE6
                    ev[`EV_GRANT] = 1'b1;
                end else begin
                    state_next = S_IDLE;
                end
            end
        end
        S_REQ: begin
            if (expired) begin
                if (target_present[sel_target]) begin
                    state_next = S_BUSY;
                    ev[`EV_DELIVER] = 1'b1; // RULE6
                end else begin
                    state_next = S_TMO; // RULE12
                    cnt_next = timeout_reg; // RULE10
                end
            end
        end
        S_BUSY: begin
            // Response timing belongs to the target
            if (xfer_done) begin // RULE7
                state_next = S_ARB;
                owned_next = 1'b0; // RULE14
                cnt_next = gap_cycles; // RULE2 RULE9
                ev[`EV_DONE] = 1'b1;
            end
        end
        S_TMO: begin
            if (expired) begin
                state_next = S_ARB;
                owned_next = 1'b0;
                cnt_next = gap_cycles; // RULE2
                ev[`EV_TIMEOUT] = 1'b1; // RULE12
            end
        end
        default: begin
            state_next = S_IDLE;
            owned_next = 1'b0;
        end
    endcase
end

// Sequencer registers and device outputs
always @(posedge clk) begin
    if (sys_rst) begin
        state_reg <= S_IDLE;
        cnt_reg <= 24'h000000;
        owner_reg <= {`ID_W{1'b0}};
        owned_reg <= 1'b0;
        pend_reg <= {`NUM_IDS{1'b0}};
        grant <= {`NUM_IDS{1'b0}};
        deliver <= 1'b0;
        deliver_target <= {`ID_W{1'b0}};
        timeout_resp <= 1'b0;
    end else if (ce) begin
        state_reg <= state_next;
        cnt_reg <= cnt_next;
        owner_reg <= owner_next;
        owned_reg <= owned_next;
        // New requests win over the clear of the granted one
        pend_reg <= (pend_reg & ~pend_clr) | arb_req; // RULE1
        grant <= owned_next ? onehot(owner_next) : {`NUM_IDS{1'b0}}; // RULE14
        deliver <= ev[`EV_DELIVER];
        if (ev[`EV_DELIVER] | (state_reg == S_REQ && expired)) begin
            deliver_target <= sel_target;
        end
        timeout_resp <= ev[`EV_TIMEOUT]; // RULE12
    end
end

////////////////////////////////////////////////////////////////////////
// Register read mux
always @* begin
    case (haddr[7:0])
        `OFF_ARB_DELAY: rd_data = {16'h0000, arb_delay_reg};
        `OFF_BUS_FREE: rd_data = {16'h0000, bus_free_reg};
        `OFF_REQ_DELAY: rd_data = {16'h0000, req_delay_reg};
        `OFF_TIMEOUT: rd_data = {8'h00, timeout_reg};
        `OFF_FREQ: rd_data = {24'h000000, freq_reg};
        `OFF_STATUS: rd_data = {28'h0000000, status_reg};
        `OFF_MASK: rd_data = {28'h0000000, mask_reg};
        `OFF_STATE: rd_data = {23'h000000, owned_reg, owner_reg, 1'b0,
                               state_reg};
        `OFF_PENDING: rd_data = {16'h0000, pend_reg};
        default: rd_data = 32'h00000000;
    endcase
end

// AHB-Lite slave: zero wait states, always OKAY
always @(posedge clk) begin
    if (sys_rst) begin
        hrdata <= 32'h00000000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        wr_pend_reg <= 1'b0;
        wr_addr_reg <= 8'h00;
    end else if (ce) begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        wr_pend_reg <= addr_phase & hwrite;
        if (addr_phase) begin
            wr_addr_reg <= haddr[7:0];
        end
        if (addr_phase & ~hwrite) begin
            hrdata <= rd_data;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Configuration writes in the data phase
always @(posedge clk) begin
    if (sys_rst) begin
        arb_delay_reg <= `RST_ARB_DELAY; // RULE8
        bus_free_reg <= `RST_BUS_FREE; // RULE9
        req_delay_reg <= `RST_REQ_DELAY; // RULE6
        timeout_reg <= `RST_TIMEOUT; // RULE10
        freq_reg <= `RST_FREQ; // RULE11
        mask_reg <= {`EV_W{1'b0}};
    end else if (ce && wr_pend_reg) begin
        case (wr_addr_reg)
            `OFF_ARB_DELAY: arb_delay_reg <= hwdata[15:0];
            `OFF_BUS_FREE: bus_free_reg <= hwdata[15:0];
            `OFF_REQ_DELAY: req_delay_reg <= hwdata[15:0];
            `OFF_TIMEOUT: timeout_reg <= hwdata[23:0];
            `OFF_FREQ: freq_reg <= hwdata[7:0];
            `OFF_MASK: mask_reg <= hwdata[`EV_W-1:0];
            default: mask_reg <= mask_reg;
        endcase
    end
end

// Sticky events, cleared by status read; a new event wins
always @(posedge clk) begin
    if (sys_rst) begin
        status_reg <= {`EV_W{1'b0}};
        irq <= 1'b0;
    end else if (ce) begin
        if (addr_phase && !hwrite && haddr[7:0] == `OFF_STATUS) begin
            status_reg <= ev;
            irq <= |(ev & mask_reg);
        end else begin
            status_reg <= status_reg | ev;
            irq <= |((status_reg | ev) & mask_reg);
        end
    end
end

endmodule // scsi_bus_arbiter

// *** test/scsi_arb_props.sv ***
/* Port checker for the bus arbiter.
   Assumes a bind from the bench top. */
`timescale 1ns/10ps
`include "scsi_arb_defines.vh"

module scsi_arb_props (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Device side
    input wire [`NUM_IDS-1:0] grant,
    input wire [`NUM_IDS-1:0] target_present,
    input wire [`ID_W-1:0] sel_target,
    input wire [`ID_W-1:0] deliver_target,
    input wire deliver,
    input wire timeout_resp,
    input wire xfer_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    // Ownership
    grant_onehot_a: assert property ($onehot0(grant))
        else $error("several grants");
    grant_hold_a: assert property (
        grant != 0 |=> grant == 0 || grant == $past(grant))
        else $error("grant moved");
    done_release_a: assert property (
        xfer_done && grant != 0 |-> ##[1:2] grant == 0)
        else $error("grant kept after done");
    // Delivery
    deliver_owned_a: assert property (deliver |-> grant != 0)
        else $error("delivery without owner");
    deliver_pulse_a: assert property (deliver |=> !deliver)
        else $error("delivery too long");
    deliver_target_a: assert property (
        deliver |-> deliver_target == sel_target
            && target_present[sel_target])
        else $error("wrong delivery");
    // Missing target
    timeout_absent_a: assert property (
        timeout_resp |-> !target_present[deliver_target])
        else $error("timeout on present target");
    timeout_release_a: assert property (
        timeout_resp |-> ##[0:1] grant == 0)
        else $error("grant kept after timeout");
    // Main scenarios
    cover property ($rose(grant != 0));
    cover property (deliver);
    cover property (timeout_resp);
endmodule // scsi_arb_props

// *** test/scsi_dev_model.sv ***
/* Far-side devices: initiators and targets on the bus.
   Assumes bench control inputs change at rising edges. */
`timescale 1ns/10ps
`include "scsi_arb_defines.vh"

module scsi_dev_model (
    // Clock
    input wire clk,
    // Bench control
    input wire [`NUM_IDS-1:0] raise,
    input wire [`NUM_IDS-1:0] present,
    input wire [`ID_W-1:0] tgt,
    input wire [7:0] resp_dly,
    // Arbiter side
    input wire [`NUM_IDS-1:0] grant,
    input wire deliver,
    output logic [`NUM_IDS-1:0] arb_req,
    output logic [`ID_W-1:0] sel_target,
    output logic [`NUM_IDS-1:0] target_present,
    output logic xfer_done
);
    logic [7:0] cnt_reg = 8'h00;
    logic busy_reg = 1'b0;
    initial begin
        arb_req = '0;
        sel_target = '0;
        target_present = '0;
        xfer_done = 1'b0;
    end
    ////////////////////////////////////////
    // Requests, target choice and answers
    always @(posedge clk) begin
        arb_req <= raise;
        target_present <= present;
        // Undriven target lines keep changing
        sel_target <= (grant != 0) ? tgt : ~sel_target;
        xfer_done <= 1'b0;
        if (deliver) begin
            busy_reg <= 1'b1;
            cnt_reg <= resp_dly;
        end else if (busy_reg && cnt_reg == 8'h00) begin
            busy_reg <= 1'b0;
            xfer_done <= 1'b1;
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end
endmodule // scsi_dev_model

// *** test/testbench.sv ***
/* Bench for the arbiter: register, arbitration, delivery,
   timeout and interrupt tests. Assumes scsi_dev_model. */
`timescale 1ns/10ps
`include "scsi_arb_defines.vh"

module testbench;
    logic clk, sys_rst, ce, hsel, hwrite;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire [31:0] hrdata;
    wire hready, hreadyout, hresp, deliver, timeout_resp, irq, xfer_done;
    wire [`NUM_IDS-1:0] arb_req, target_present, grant;
    wire [`ID_W-1:0] sel_target, deliver_target;
    logic [`NUM_IDS-1:0] raise, present, g_prev;
    logic [`ID_W-1:0] tgt;
    logic [7:0] resp_dly;
    int err_total, tests_run, cyc, t0, n_g, n_d, n_t, n_x, t_g, t_d, t_t, t_x;
    logic [31:0] rst_tab [9] = '{32'h18, 32'h8, 32'hd, 32'h2710, 32'ha,
        32'h0, 32'h0, 32'h0, 32'h0};
    assign hready = hreadyout;
    scsi_bus_arbiter i_scsi_bus_arbiter (.clk(clk), .sys_rst(sys_rst),
        .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .arb_req(arb_req), .sel_target(sel_target),
        .target_present(target_present), .xfer_done(xfer_done),
        .grant(grant), .deliver(deliver), .deliver_target(deliver_target),
        .timeout_resp(timeout_resp), .irq(irq));
    scsi_dev_model i_scsi_dev_model (.clk(clk), .raise(raise),
        .present(present), .tgt(tgt), .resp_dly(resp_dly), .grant(grant),
        .deliver(deliver), .arb_req(arb_req), .sel_target(sel_target),
        .target_present(target_present), .xfer_done(xfer_done));
    ////////////////////////////////////////
    // Event times in clock cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        g_prev <= grant;
        n_g <= n_g + int'(grant != 0 && g_prev == 0);
        if (grant != 0 && g_prev == 0) t_g <= cyc;
        n_d <= n_d + int'(deliver === 1'b1);
        if (deliver === 1'b1) t_d <= cyc;
        n_t <= n_t + int'(timeout_resp === 1'b1);
        if (timeout_resp === 1'b1) t_t <= cyc;
        n_x <= n_x + int'(xfer_done === 1'b1);
        if (xfer_done === 1'b1) t_x <= cyc;
    end
    // One single AHB-Lite transfer
    task automatic bus(input logic [7:0] a, input logic w,
            input logic [31:0] d);
        @(posedge clk);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    // Value and span comparisons
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic span(input int v, input int lo, input int hi);
        tests_run++;
        if (v < lo || v > hi) begin
            err_total++;
            $display("Error %0t: span %0d not in %0d..%0d", $time, v, lo, hi);
        end
    endtask
    task automatic pulse(input logic [15:0] ids);
        @(posedge clk);
        raise <= ids;
        t0 = cyc;
        @(posedge clk);
        raise <= 16'h0;
    endtask
    task automatic results;
        $display("Checks %0d, errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #40000;
        err_total++;
        $display("Error %0t: watchdog expired", $time);
        results();
    end
    // Main sequence
    initial begin
        {sys_rst, ce, hsel, hwrite, haddr, hwdata} = {3'b111, 65'h0};
        {htrans, hsize, raise} = {2'b00, 3'b010, 16'h0};
        {present, tgt, resp_dly} = {16'h00ff, 4'h2, 8'd20};
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            bus(8'(i * 4), 1'b0, 32'h0);
            chk(rd, rst_tab[i]);
        end
        bus(8'h40, 1'b0, 32'h0);
        chk(rd, 32'h0);
        chk(hresp, 32'h0);
        // Tick every clock, short delays, all events unmasked
        bus(8'h10, 1'b1, 32'hfa);
        bus(8'h00, 1'b1, 32'h8);
        bus(8'h04, 1'b1, 32'h7);
        bus(8'h08, 1'b1, 32'h5);
        bus(8'h0c, 1'b1, 32'h9);
        bus(8'h18, 1'b1, 32'hf);
        bus(8'h00, 1'b0, 32'h0);
        chk(rd, 32'h8);
        // Two requests on an idle bus, slow target
        pulse(16'h0208);
        repeat (400) if (n_g < 1) @(posedge clk);
        chk(grant, 32'h0200);
        span(t_g - t0, 8, 13);
        repeat (200) if (n_d < 1) @(posedge clk);
        chk(deliver_target, 4'h2);
        span(t_d - t_g, 4, 8);
        repeat (400) if (n_x < 1) @(posedge clk);
        tgt <= 4'hc;
        repeat (400) if (n_g < 2) @(posedge clk);
        chk(grant, 32'h0008);
        span(t_g - t_x, 15, 21);
        // Missing target times out
        repeat (400) if (n_t < 1) @(posedge clk);
        span(t_t - t_g, 13, 19);
        chk(deliver_target, 4'hc);
        chk(irq, 1'b1);
        bus(8'h14, 1'b0, 32'h0);
        chk(rd, 32'hf);
        @(posedge clk);
        chk(irq, 1'b0);
        chk(grant, 32'h0);
        // Masked events, extreme IDs, prompt target
        bus(8'h18, 1'b1, 32'h0);
        tgt <= 4'h1;
        resp_dly <= 8'd0;
        pulse(16'h8001);
        repeat (400) if (n_g < 3) @(posedge clk);
        chk(grant, 32'h8000);
        bus(8'h1c, 1'b0, 32'h0);
        chk(rd, 32'h1f2);
        bus(8'h20, 1'b0, 32'h0);
        chk(rd, 32'h0001);
        repeat (400) if (n_g < 4) @(posedge clk);
        chk(grant, 32'h0001);
        repeat (400) if (n_x < 3) @(posedge clk);
        chk(irq, 1'b0);
        bus(8'h14, 1'b0, 32'h0);
        chk(rd, 32'hb);
        results();
    end
endmodule // testbench

bind scsi_bus_arbiter scsi_arb_props i_scsi_arb_props (.clk(clk),
    .sys_rst(sys_rst), .grant(grant), .target_present(target_present),
    .sel_target(sel_target), .deliver_target(deliver_target),
    .deliver(deliver), .timeout_resp(timeout_resp), .xfer_done(xfer_done));
